// ===== core/pcg_pkg.sv
/*
  Constants for the upper peripheral clock gating block: register byte
  addresses, field positions, reset values, the protection key and the
  interrupt event layout.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package pcg_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] PCG_ADDR_PROT_MODE   = 32'h400E_06E4;
  localparam logic [31:0] PCG_ADDR_PROT_STATUS = 32'h400E_06E8;
  localparam logic [31:0] PCG_ADDR_UPPER_EN    = 32'h400E_0700;
  localparam logic [31:0] PCG_ADDR_UPPER_DIS   = 32'h400E_0704;
  localparam logic [31:0] PCG_ADDR_UPPER_STATE = 32'h400E_0708;
  localparam logic [31:0] PCG_ADDR_PERIPH_CTRL = 32'h400E_070C;
  localparam logic [31:0] PCG_ADDR_IRQ_STATUS  = 32'h400E_0710;
  localparam logic [31:0] PCG_ADDR_IRQ_ENABLE  = 32'h400E_0714;
  localparam logic [31:0] PCG_ADDR_IRQ_CLEAR   = 32'h400E_0718;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int          PCG_KEY_LSB     = 8;
  localparam int          PCG_KEY_W       = 24;
  localparam logic [23:0] PCG_PROT_KEY    = 24'h50_4D43;
  localparam int          PCG_PEN_BIT     = 0;
  localparam int          PCG_VFLAG_BIT   = 0;
  localparam int          PCG_VSRC_LSB    = 8;
  localparam int          PCG_VSRC_W      = 16;
  localparam int          PCG_UPPER_BASE  = 32;
  localparam int          PCG_UPPER_N     = 13;
  localparam int          PCG_SEL_LSB     = 0;
  localparam int          PCG_SEL_W       = 6;
  localparam int          PCG_CMD_BIT     = 12;
  localparam int          PCG_DIV_LSB     = 16;
  localparam int          PCG_DIV_W       = 2;
  localparam int          PCG_EN_BIT      = 28;
  localparam logic [5:0]  PCG_SEL_MIN     = 6'h02;
  localparam int          PCG_NUM_PERIPH  = 64;

  // ----------------------------------------------------------------------
  // Divider codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PCG_DIV_1       = 2'h0;
  localparam logic [1:0]  PCG_DIV_2       = 2'h1;
  localparam logic [1:0]  PCG_DIV_4       = 2'h2;
  localparam logic [63:0] PCG_GATE_RST    = 64'h0000_0000_0000_0000;
  localparam logic [31:0] PCG_WORD_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  localparam int          PCG_EV_N        = 3;
  localparam int          PCG_EV_VIOL     = 0;
  localparam int          PCG_EV_DIV_BAD  = 1;
  localparam int          PCG_EV_DIV_LIVE = 2;

  // ----------------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PCG_ST_IDLE = 2'b00,
    PCG_ST_WR   = 2'b01,
    PCG_ST_RDW  = 2'b10,
    PCG_ST_RDD  = 2'b11
  } pcg_bus_e;

endpackage : pcg_pkg

// ===== core/pcg_div.sv
/*
  Clock-enable divider for one peripheral: master clock, half or quarter
  rate, as a one-cycle enable pulse.
  Assumes the divider code is stable while the gate is on.
*/
`timescale 1ns/10ps
module pcg_div
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] div,
  // Enable pulse
  output logic            tick_r
);

  logic [1:0] cnt_r;
  wire  [1:0] mask = (div == PCG_DIV_4) ? 2'h3 : ((div == PCG_DIV_2) ? 2'h1 : 2'h0);
  wire        hit  = run && ((cnt_r & mask) == 2'h0);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= run ? cnt_r + 2'h1 : 2'h0;
      tick_r <= hit;
    end
  end

endmodule : pcg_div

// ===== core/pcg_irq.sv
/*
  Sticky event status, enable mask and write-only clear, folded onto one
  level interrupt output.
  Assumes event and clear strobes are one-cycle pulses on sys_clk.
*/
`timescale 1ns/10ps
module pcg_irq
  import pcg_pkg::*;
#(
  parameter int N = PCG_EV_N
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Events and software access
  input  wire logic [N-1:0] event_set,
  input  wire logic         enable_we,
  input  wire logic         clear_we,
  input  wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0]      status_r,
  output logic [N-1:0]      enable_r,
  output logic              irq_r
);

  // A new event wins over a clear in the same cycle.
  wire [N-1:0] status_nxt = event_set | (status_r & ~(clear_we ? wdata : {N{1'b0}}));
  wire [N-1:0] enable_nxt = enable_we ? wdata : enable_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_r <= '0;
      enable_r <= '0;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      irq_r    <= |(status_nxt & enable_nxt);
    end
  end

endmodule : pcg_irq

// ===== core/pcg_top.sv
/*
  Upper peripheral clock gating with write protection, reached over an
  AHB-Lite slave port. Holds the gate state of peripherals 2 to 44, the
  upper enable/disable/state registers, the per-peripheral control
  register, the dividers of the two CAN controllers and the protection
  mode and violation status registers.
  Assumes a single AHB-Lite master and hready looped back from hreadyout.
*/
// Local design decision: the AHB-Lite register port.
// Function
// - A protection violation sets a sticky flag, kept until the status register is read.
// - With the flag set, the source field holds the offset of the blocked register.
// - Reading the protection status returns it, then clears flag and source.
// - Upper enable and disable registers are written only while protection is off.
// - Writing one to upper enable bit n starts peripheral clock 32+n.
// - Writing one to an upper disable bit stops that peripheral clock.
// - Upper state bits read one while the matching clock runs.
// - Enable bits of unimplemented peripherals change nothing.
// - Control register selects peripheral 2 to 63; command one writes, zero reads.
// - Divider code 0, 1, 2 gives master clock, half, quarter.
// - Only the two CAN controllers accept a divided clock.
// - Control register enable bit starts or stops the selected clock.
// - Protection enable changes only with the right key; the key reads zero.
`timescale 1ns/10ps
module pcg_top
  import pcg_pkg::*;
#(
  parameter logic [63:0] IMPL_MASK = 64'h0000_1FFF_FFFF_FFFC,
  parameter logic [5:0]  CAN_CONTROLLER_ZERO_ID   = 6'h2B,
  parameter logic [5:0]  CAN_CONTROLLER_ONE_ID   = 6'h2C
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Clock gates and divided enables
  output logic [63:0]      periph_clk_on,
  output logic [1:0]       can_clk_tick,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_reg(input logic [31:0] a, input logic [31:0] r);
    is_reg = (a == r);
  endfunction : is_reg

  function automatic logic [63:0] onehot(input logic [5:0] id);
    onehot = 64'h0000_0000_0000_0001 << id;
  endfunction : onehot

  // ----------------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------------
  pcg_bus_e    state_r;
  pcg_bus_e    state_nxt;
  logic [31:0] addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;

  // Every read takes one wait state so that a write in the cycle before is
  // already visible, and read-to-clear acts once per completed read.
  wire ap_take = hsel && htrans[1] && hready;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PCG_ST_IDLE,
      PCG_ST_WR,
      PCG_ST_RDD:
      begin
        if (ap_take)
          state_nxt = hwrite ? PCG_ST_WR : PCG_ST_RDW;
        else
          state_nxt = PCG_ST_IDLE;
      end
      PCG_ST_RDW:
        state_nxt = PCG_ST_RDD;
      default:
        state_nxt = PCG_ST_IDLE;
    endcase
  end

  wire wr_fire = (state_r == PCG_ST_WR);
  wire rd_load = (state_r == PCG_ST_RDW);

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire sel_mode  = is_reg(addr_r, PCG_ADDR_PROT_MODE);
  wire sel_stat  = is_reg(addr_r, PCG_ADDR_PROT_STATUS);
  wire sel_uen   = is_reg(addr_r, PCG_ADDR_UPPER_EN);
  wire sel_udis  = is_reg(addr_r, PCG_ADDR_UPPER_DIS);
  wire sel_ustat = is_reg(addr_r, PCG_ADDR_UPPER_STATE);
  wire sel_pctl  = is_reg(addr_r, PCG_ADDR_PERIPH_CTRL);
  wire sel_ists  = is_reg(addr_r, PCG_ADDR_IRQ_STATUS);
  wire sel_ien   = is_reg(addr_r, PCG_ADDR_IRQ_ENABLE);
  wire sel_iclr  = is_reg(addr_r, PCG_ADDR_IRQ_CLEAR);

  // ----------------------------------------------------------------------
  // Write protection
  // ----------------------------------------------------------------------
  logic                  prot_en_r;
  logic                  vflag_r;
  logic [PCG_VSRC_W-1:0] vsrc_r;

  wire key_ok     = (hwdata[PCG_KEY_LSB +: PCG_KEY_W] == PCG_PROT_KEY);
  wire mode_we    = wr_fire && sel_mode && key_ok;
  wire prot_hit   = wr_fire && (sel_uen || sel_udis);
  wire violation  = prot_hit && prot_en_r;
  wire upper_ok   = prot_hit && !prot_en_r;
  wire stat_clear = rd_load && sel_stat;

  wire                  prot_en_nxt = mode_we ? hwdata[PCG_PEN_BIT] : prot_en_r;
  // A violation in the cycle of the clearing read wins and stays visible.
  wire                  vflag_nxt   = violation | (vflag_r & ~stat_clear);
  wire [PCG_VSRC_W-1:0] vsrc_nxt    = violation  ? addr_r[PCG_VSRC_W-1:0] :
                                      stat_clear ? '0 : vsrc_r;

  // ----------------------------------------------------------------------
  // Upper enable and disable
  // ----------------------------------------------------------------------
  wire [63:0] wd_upper = {{(64-PCG_UPPER_BASE-PCG_UPPER_N){1'b0}},
                          hwdata[PCG_UPPER_N-1:0],
                          {PCG_UPPER_BASE{1'b0}}};
  wire [63:0] set_up   = (upper_ok && sel_uen)  ? wd_upper : '0;
  wire [63:0] clr_up   = (upper_ok && sel_udis) ? wd_upper : '0;

  // ----------------------------------------------------------------------
  // Peripheral control register
  // ----------------------------------------------------------------------
  logic [PCG_SEL_W-1:0] psel_r;
  logic [63:0]          gate_r;
  logic [1:0]           div_r [2];

  wire                 pctl_we  = wr_fire && sel_pctl;
  wire [PCG_SEL_W-1:0] wr_sel   = hwdata[PCG_SEL_LSB +: PCG_SEL_W];
  wire                 wr_cmd   = hwdata[PCG_CMD_BIT];
  wire [1:0]           wr_div   = hwdata[PCG_DIV_LSB +: PCG_DIV_W];
  wire                 wr_en    = hwdata[PCG_EN_BIT];
  wire                 sel_ok   = (wr_sel >= PCG_SEL_MIN);
  wire                 pctl_act = pctl_we && wr_cmd && sel_ok;
  wire                 is_can_controller_zero  = (wr_sel == CAN_CONTROLLER_ZERO_ID);
  wire                 is_can_controller_one  = (wr_sel == CAN_CONTROLLER_ONE_ID);
  wire                 div_code = (wr_div != 2'h3);
  wire [63:0]          sel_hot  = onehot(wr_sel);

  // A non-zero divider for a peripheral without a divider is dropped.
  wire div_bad  = pctl_act && !(is_can_controller_zero || is_can_controller_one)
                  && (wr_div != PCG_DIV_1);
  wire can_controller_zero_we  = pctl_act && is_can_controller_zero && div_code;
  wire can_controller_one_we  = pctl_act && is_can_controller_one && div_code;
  // Changing a divider under a running clock breaks the peripheral; it is
  // applied anyway but flagged so that the fault can be traced.
  wire div_live = (can_controller_zero_we && gate_r[CAN_CONTROLLER_ZERO_ID] && (wr_div != div_r[0]))
               || (can_controller_one_we && gate_r[CAN_CONTROLLER_ONE_ID] && (wr_div != div_r[1]));

  wire [63:0] set_pc = (pctl_act &&  wr_en) ? sel_hot : '0;
  wire [63:0] clr_pc = (pctl_act && !wr_en) ? sel_hot : '0;

  // Unimplemented identifiers never change state.
  wire [63:0] gate_nxt = ((gate_r | set_up | set_pc) & ~(clr_up | clr_pc))
                         & IMPL_MASK;

  wire [PCG_SEL_W-1:0] psel_nxt = pctl_we ? wr_sel : psel_r;
  wire [1:0]           div0_nxt = can_controller_zero_we ? wr_div : div_r[0];
  wire [1:0]           div1_nxt = can_controller_one_we ? wr_div : div_r[1];

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [PCG_EV_N-1:0] ists_r;
  logic [PCG_EV_N-1:0] ien_r;
  logic                irq_r;
  wire  [PCG_EV_N-1:0] ev_set;

  assign ev_set[PCG_EV_VIOL]     = violation;
  assign ev_set[PCG_EV_DIV_BAD]  = div_bad;
  assign ev_set[PCG_EV_DIV_LIVE] = div_live;

  pcg_irq #(
    .N (PCG_EV_N)
  ) u_irq (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .event_set (ev_set),
    .enable_we (wr_fire && sel_ien),
    .clear_we  (wr_fire && sel_iclr),
    .wdata     (hwdata[PCG_EV_N-1:0]),
    .status_r  (ists_r),
    .enable_r  (ien_r),
    .irq_r     (irq_r)
  );

  // ----------------------------------------------------------------------
  // Divided clock enables of the two CAN controllers
  // ----------------------------------------------------------------------
  logic [1:0] tick;
  wire  [5:0] can_id [2];
  assign can_id[0] = CAN_CONTROLLER_ZERO_ID;
  assign can_id[1] = CAN_CONTROLLER_ONE_ID;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_can
      pcg_div u_div (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .run     (gate_r[can_id[gi]]),
        .div     (div_r[gi]),
        .tick_r  (tick[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [1:0] sel_div = (psel_r == CAN_CONTROLLER_ZERO_ID) ? div_r[0] :
                       (psel_r == CAN_CONTROLLER_ONE_ID) ? div_r[1] : PCG_DIV_1;

  wire [31:0] rd_mode  = {{(32-1){1'b0}}, prot_en_r};
  wire [31:0] rd_stat  = {8'h00, vsrc_r, 7'h00, vflag_r};
  wire [31:0] rd_ustat = {{(32-PCG_UPPER_N){1'b0}},
                          gate_r[PCG_UPPER_BASE +: PCG_UPPER_N]};
  wire [31:0] rd_pctl  = {3'h0, gate_r[psel_r], 10'h000, sel_div,
                          10'h000, psel_r};
  wire [31:0] rd_ists  = {{(32-PCG_EV_N){1'b0}}, ists_r};
  wire [31:0] rd_ien   = {{(32-PCG_EV_N){1'b0}}, ien_r};

  wire [31:0] rd_mux = sel_mode  ? rd_mode  :
                       sel_stat  ? rd_stat  :
                       sel_ustat ? rd_ustat :
                       sel_pctl  ? rd_pctl  :
                       sel_ists  ? rd_ists  :
                       sel_ien   ? rd_ien   : PCG_WORD_ZERO;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r     <= PCG_ST_IDLE;
      addr_r      <= PCG_WORD_ZERO;
      hrdata_r    <= PCG_WORD_ZERO;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      addr_r      <= ap_take ? haddr : addr_r;
      hrdata_r    <= rd_load ? rd_mux : hrdata_r;
      hreadyout_r <= (state_nxt != PCG_ST_RDW);
      hresp_r     <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prot_en_r <= 1'b0;
      vflag_r   <= 1'b0;
      vsrc_r    <= '0;
      gate_r    <= PCG_GATE_RST;
      psel_r    <= '0;
      div_r[0]  <= PCG_DIV_1;
      div_r[1]  <= PCG_DIV_1;
    end
    else
    begin
      prot_en_r <= prot_en_nxt;
      vflag_r   <= vflag_nxt;
      vsrc_r    <= vsrc_nxt;
      gate_r    <= gate_nxt;
      psel_r    <= psel_nxt;
      div_r[0]  <= div0_nxt;
      div_r[1]  <= div1_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata        = hrdata_r;
  assign hreadyout     = hreadyout_r;
  assign hresp         = hresp_r;
  assign periph_clk_on = gate_r;
  assign can_clk_tick  = tick;
  assign irq           = irq_r;

endmodule : pcg_top

// ===== sim/pcg_monitor.sv
/*
  Port checker for the clock gating block.
  Assumes hready is looped back from hreadyout and one bus master.
*/
`timescale 1ns/10ps
module pcg_monitor
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Gates
  input wire logic [63:0] periph_clk_on,
  input wire logic [1:0]  can_clk_tick
);
  // ----
  // Data phase tracking
  // ----
  logic        dph_v_r;
  logic        dph_wr_r;
  logic [31:0] dph_addr_r;
  logic        prot_r;
  wire         take    = hsel & htrans[1] & hready;
  wire         wr_done = dph_v_r & dph_wr_r & hready;
  wire         wr_en   = wr_done & (dph_addr_r == PCG_ADDR_UPPER_EN);
  wire         wr_dis  = wr_done & (dph_addr_r == PCG_ADDR_UPPER_DIS);
  wire         key_ok  = hwdata[31:8] == PCG_PROT_KEY;
  wire         wr_ctl  = wr_done & (dph_addr_r == PCG_ADDR_PERIPH_CTRL) & hwdata[PCG_CMD_BIT]
                         & (hwdata[5:0] >= 6'h02) & (hwdata[5:0] <= 6'h2C);

  // Protection is tracked here so the gate checks know when writes must bounce.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dph_v_r    <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 32'h0000_0000;
      prot_r     <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        dph_v_r    <= take;
        dph_wr_r   <= hwrite;
        dph_addr_r <= haddr;
      end
      if (wr_done && dph_addr_r == PCG_ADDR_PROT_MODE && key_ok)
        prot_r <= hwdata[PCG_PEN_BIT];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_gate_off;
    !periph_clk_on[43] ##1 !periph_clk_on[43];
  endsequence

  property p_read_wait;
    take && !hwrite |=> s_read_answer;
  endproperty
  property p_en_sets;
    wr_en && !prot_r |=> (periph_clk_on[44:32] & $past(hwdata[12:0])) == $past(hwdata[12:0]);
  endproperty
  property p_dis_clears;
    wr_dis && !prot_r |=> (periph_clk_on[44:32] & $past(hwdata[12:0])) == 13'h0000;
  endproperty
  property p_blocked;
    (wr_en || wr_dis) && prot_r |=> $stable(periph_clk_on);
  endproperty
  property p_unimpl;
    periph_clk_on[1:0] == 2'h0 && periph_clk_on[63:45] == 19'h0_0000;
  endproperty
  property p_ctl_en;
    wr_ctl |=> periph_clk_on[$past(hwdata[5:0])] == $past(hwdata[PCG_EN_BIT]);
  endproperty
  property p_quiet;
    !wr_done |=> $stable(periph_clk_on);
  endproperty
  property p_tick_off;
    s_gate_off |-> !can_clk_tick[0];
  endproperty

  a_read_wait: assert property (p_read_wait)
    else $error("read answer timing wrong");
  a_en_sets: assert property (p_en_sets)
    else $error("enable write did not start clocks");
  a_dis_clears: assert property (p_dis_clears)
    else $error("disable write did not stop clocks");
  a_blocked: assert property (p_blocked)
    else $error("protected write changed gates");
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented gate on");
  a_ctl_en: assert property (p_ctl_en)
    else $error("control enable not applied");
  a_quiet: assert property (p_quiet)
    else $error("gate changed without write");
  a_tick_off: assert property (p_tick_off)
    else $error("tick while gate off");
endmodule : pcg_monitor

bind pcg_top pcg_monitor mon_u (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .periph_clk_on(periph_clk_on), .can_clk_tick(can_clk_tick));

// ===== sim/peripheral_clock_gating_wp_bench.sv
/*
  Self-checking bench for the clock gating block.
  Assumes the design answers writes at once and reads after one wait.
*/
`timescale 1ns/10ps
module peripheral_clock_gating_wp_bench
  import pcg_pkg::*;
();
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [63:0] periph_clk_on;
  logic [1:0]  can_clk_tick;
  logic        irq;
  logic [15:0] seed    = 16'hDD48;
  logic [12:0] gates   = 13'h0000;
  logic [1:0]  cur_div [64] = '{default: 2'h0};
  logic [31:0] rd;
  logic [31:0] d;
  logic [5:0]  id;
  logic [1:0]  dv;
  int          fails   = 0;
  int          num_checks = 0;
  int          n;

  pcg_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periph_clk_on(periph_clk_on),
    .can_clk_tick(can_clk_tick), .irq(irq));

  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] ctl(input logic c, input logic e, input logic [1:0] v,
                                      input logic [5:0] p);
    return {3'h0, e, 10'h000, v, 3'h0, c, 6'h00, p};
  endfunction : ctl

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
      @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
      @(posedge sys_clk);
    rd = hrdata;
    #1;
  endtask : bus

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
    check("hresp", hresp, 1'b0);
  endtask : rdchk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial
  begin
    #500000;
    fails++;
    stop_test();
  end

  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdchk(PCG_ADDR_UPPER_STATE, 32'h0000_0000, "state at reset");
    rdchk(PCG_ADDR_PROT_STATUS, 32'h0000_0000, "violation at reset");
    rdchk(32'h400E_0720, 32'h0000_0000, "unmapped");
    $display("test reset done");
    repeat (12)
    begin
      seed = lfsr(seed);
      d = {seed, ~seed};
      bus(1'b1, seed[0] ? PCG_ADDR_UPPER_DIS : PCG_ADDR_UPPER_EN, d);
      gates = seed[0] ? gates & ~d[12:0] : gates | d[12:0];
      rdchk(PCG_ADDR_UPPER_STATE, {19'h0_0000, gates}, "upper state");
    end
    $display("test upper gates done");
    bus(1'b1, PCG_ADDR_UPPER_EN, 32'h0000_1FFF);
    bus(1'b1, PCG_ADDR_PROT_MODE, 32'h504D_4201);
    bus(1'b1, PCG_ADDR_UPPER_DIS, 32'h0000_0001);
    rdchk(PCG_ADDR_PROT_MODE, 32'h0000_0000, "bad key");
    bus(1'b1, PCG_ADDR_PROT_MODE, {PCG_PROT_KEY, 8'h01});
    rdchk(PCG_ADDR_PROT_MODE, 32'h0000_0001, "good key");
    bus(1'b1, PCG_ADDR_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, PCG_ADDR_UPPER_DIS, 32'h0000_1FFF);
    rdchk(PCG_ADDR_UPPER_STATE, 32'h0000_1FFE, "blocked");
    check("irq raised", irq, 1);
    rdchk(PCG_ADDR_PROT_STATUS, 32'h0007_0401, "source disable");
    rdchk(PCG_ADDR_PROT_STATUS, 32'h0000_0000, "read clears");
    bus(1'b1, PCG_ADDR_UPPER_EN, 32'h0000_0001);
    rdchk(PCG_ADDR_PROT_STATUS, 32'h0007_0001, "source enable");
    bus(1'b1, PCG_ADDR_IRQ_CLEAR, 32'h0000_0001);
    bus(1'b1, PCG_ADDR_IRQ_ENABLE, 32'h0000_0000);
    bus(1'b1, PCG_ADDR_UPPER_EN, 32'h0000_0001);
    rdchk(PCG_ADDR_IRQ_STATUS, 32'h0000_0001, "event sticky");
    check("irq masked", irq, 0);
    bus(1'b1, PCG_ADDR_IRQ_CLEAR, 32'h0000_0001);
    bus(1'b1, PCG_ADDR_PROT_MODE, {PCG_PROT_KEY, 8'h00});
    $display("test protection done");
    for (int i = 0; i < 3; i++)
    begin
      id = (i == 1) ? 6'h2C : 6'h2B;
      dv = 2'(2 - i);
      bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b0, cur_div[id], id));
      bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b0, dv, id));
      bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b1, dv, id));
      cur_div[id] = dv;
      rdchk(PCG_ADDR_PERIPH_CTRL, ctl(1'b0, 1'b1, dv, id), "control");
      n = 0;
      repeat (16)
      begin
        @(posedge sys_clk);
        n += (can_clk_tick[id - 6'h2B] === 1'b1) ? 1 : 0;
      end
      check("ticks", n, 16 >> dv);
    end
    bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b1, PCG_DIV_2, 6'h05));
    check("plain gate", periph_clk_on[5], 1);
    rdchk(PCG_ADDR_PERIPH_CTRL, ctl(1'b0, 1'b1, PCG_DIV_1, 6'h05), "no divider");
    rdchk(PCG_ADDR_IRQ_STATUS, 32'h0000_0002, "bad divider");
    bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b1, 2'h3, 6'h2B));
    rdchk(PCG_ADDR_PERIPH_CTRL, ctl(1'b0, 1'b1, cur_div[6'h2B], 6'h2B), "code 3");
    bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, 1'b1, PCG_DIV_1, 6'h01));
    check("low ids", periph_clk_on[1:0], 0);
    repeat (8)
    begin
      seed = lfsr(seed);
      id = 6'(2 + seed[7:0] % 43);
      bus(1'b1, PCG_ADDR_PERIPH_CTRL, ctl(1'b1, seed[8], cur_div[id], id));
      check("control gate", periph_clk_on[id], seed[8]);
    end
    $display("test control done");
    stop_test();
  end
endmodule : peripheral_clock_gating_wp_bench
